//--- verilog/store_rmw_bus_sequencer.sv
// Bus sequencer for store and read-modify-write instructions.
// Assumes memory answers a read in the cycle its address is driven.
//
// Operation
// - Absolute indexed store: five cycles, dummy then write
// - Absolute store fetches opcode, pc+1, pc+2, pc+3
// - Zero-page indexed store: four cycles, dummy, write
// - Indirect store reads pointer, then page-zero base bytes
// - Indirect-Y store: six cycles, uncorrected dummy read
// - Indirect-X store: high byte at base+X+1, write
// - Read-modify-write writes modified value to same address
// - Zero-page modify: five cycles, double write back
// - Absolute modify: six cycles, next opcode pc+3
// - Zero-page-X modify: six cycles, sum without carry
// - Absolute-X modify: always seven cycles
// - No overlap, no shortening, low only when writing
`timescale 1ns/1ps

module store_rmw_bus_sequencer #(
   parameter int DATA_W = seq_pkg::DATA_W
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              start,
   input  wire seq_pkg::cmd_s     cmd,
   input  wire logic [DATA_W-1:0] data_in,
   output seq_pkg::bus_s          bus,
   output seq_pkg::flags_s        flags,
   output logic [15:0]            next_pc,
   output logic                   busy,
   output logic                   done
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   seq_pkg::seq_s s_q;
   seq_pkg::seq_s s_d;

   logic [7:0] mod_val;
   logic       mod_carry;
   logic       mod_zero;
   logic       mod_neg;
   logic [8:0] idx_sum;
   logic [7:0] hi_fix;

   // ----------------------------------------------------------------
   // Modify stage
   // ----------------------------------------------------------------
   rmw_alu #(
      .WIDTH     (DATA_W)
   ) u_alu (
      .op        (s_q.cmd.op),
      .operand   (s_q.operand),
      .carry_in  (s_q.cmd.carry_in),
      .result    (mod_val),
      .carry_out (mod_carry),
      .zero      (mod_zero),
      .negative  (mod_neg)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic seq_pkg::bus_s rd(input logic [15:0] a);
      seq_pkg::bus_s b;
      b.addr = a;
      b.dout = 8'h00;
      b.oe   = 1'b0;
      b.rw   = 1'b1;
      return b;
   endfunction

   function automatic seq_pkg::bus_s wr(input logic [15:0] a, input logic [7:0] v);
      seq_pkg::bus_s b;
      b.addr = a;
      b.dout = v;
      b.oe   = 1'b1;
      b.rw   = 1'b0;
      return b;
   endfunction

   function automatic logic [15:0] zp(input logic [7:0] lo);
      return {seq_pkg::ZERO_PAGE, lo};
   endfunction

   // Base low plus index, carry kept in bit 8
   assign idx_sum = {1'b0, s_q.base_addr_low} + {1'b0, s_q.idx};
   // High byte arriving now, corrected by the carry
   assign hi_fix  = data_in + {7'h00, idx_sum[8]};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.bus  = rd(s_q.bus.addr);
      unique case (s_q.phase)
         seq_pkg::PH_IDLE: begin
            if (start) begin
               s_d.phase = seq_pkg::PH_RUN;
               s_d.cmd   = cmd;
               s_d.t     = 3'h0;
               s_d.busy  = 1'b1;
               s_d.bus   = rd(cmd.pc);
               unique case (cmd.mode)
                  seq_pkg::M_ST_IND_Y:  s_d.idx = cmd.y;
                  seq_pkg::M_ST_IND_X:  s_d.idx = cmd.x;
                  seq_pkg::M_RMW_ZP,
                  seq_pkg::M_RMW_ABS,
                  seq_pkg::M_RMW_ZP_X,
                  seq_pkg::M_RMW_ABS_X: s_d.idx = cmd.x;
                  default:              s_d.idx = cmd.use_y ? cmd.y : cmd.x;
               endcase
            end
         end
         seq_pkg::PH_RUN: begin
            s_d.t = s_q.t + 3'h1;
            if (s_q.t == 3'h0) begin
               s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_1);
            end else begin
               unique case (s_q.cmd.mode)
                  seq_pkg::M_ST_ABS_IDX: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                        end
                        3'h2: begin
                           s_d.base_addr_high = data_in;
                           s_d.eff_addr = {hi_fix, idx_sum[7:0]};
                           s_d.bus = rd({hi_fix, idx_sum[7:0]});
                        end
                        3'h3: s_d.bus = wr(s_q.eff_addr, s_q.cmd.store_val);
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_3);
                     endcase
                  end
                  seq_pkg::M_ST_ZP_IDX: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(zp(data_in));
                        end
                        3'h2: begin
                           s_d.eff_addr = zp(idx_sum[7:0]);
                           s_d.bus = wr(zp(idx_sum[7:0]), s_q.cmd.store_val);
                        end
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                     endcase
                  end
                  seq_pkg::M_ST_IND_Y: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.ptr = data_in;
                           s_d.bus = rd(zp(data_in));
                        end
                        3'h2: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(zp(s_q.ptr + seq_pkg::BYTE_STEP));
                        end
                        3'h3: begin
                           s_d.base_addr_high = data_in;
                           s_d.eff_addr = {hi_fix, idx_sum[7:0]};
                           s_d.bus = rd({data_in, idx_sum[7:0]});
                        end
                        3'h4: s_d.bus = wr(s_q.eff_addr, s_q.cmd.store_val);
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                     endcase
                  end
                  seq_pkg::M_ST_IND_X: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(zp(data_in));
                        end
                        3'h2: s_d.bus = rd(zp(idx_sum[7:0]));
                        3'h3: begin
                           s_d.eff_addr[7:0] = data_in;
                           s_d.bus = rd(zp(idx_sum[7:0] + seq_pkg::BYTE_STEP));
                        end
                        3'h4: begin
                           s_d.eff_addr[15:8] = data_in;
                           s_d.bus = wr({data_in, s_q.eff_addr[7:0]}, s_q.cmd.store_val);
                        end
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                     endcase
                  end
                  seq_pkg::M_RMW_ZP: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.eff_addr = zp(data_in);
                           s_d.bus = rd(zp(data_in));
                        end
                        3'h2: begin
                           s_d.operand = data_in;
                           s_d.bus = wr(s_q.eff_addr, data_in);
                        end
                        3'h3: s_d.bus = wr(s_q.eff_addr, mod_val);
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                     endcase
                  end
                  seq_pkg::M_RMW_ABS: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                        end
                        3'h2: begin
                           s_d.eff_addr = {data_in, s_q.base_addr_low};
                           s_d.bus = rd({data_in, s_q.base_addr_low});
                        end
                        3'h3: begin
                           s_d.operand = data_in;
                           s_d.bus = wr(s_q.eff_addr, data_in);
                        end
                        3'h4: s_d.bus = wr(s_q.eff_addr, mod_val);
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_3);
                     endcase
                  end
                  seq_pkg::M_RMW_ZP_X: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(zp(data_in));
                        end
                        3'h2: begin
                           s_d.eff_addr = zp(idx_sum[7:0]);
                           s_d.bus = rd(zp(idx_sum[7:0]));
                        end
                        3'h3: begin
                           s_d.operand = data_in;
                           s_d.bus = wr(s_q.eff_addr, data_in);
                        end
                        3'h4: s_d.bus = wr(s_q.eff_addr, mod_val);
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                     endcase
                  end
                  seq_pkg::M_RMW_ABS_X: begin
                     unique case (s_q.t)
                        3'h1: begin
                           s_d.base_addr_low = data_in;
                           s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_2);
                        end
                        3'h2: begin
                           s_d.base_addr_high = data_in;
                           s_d.eff_addr = {hi_fix, idx_sum[7:0]};
                           s_d.bus = rd({hi_fix, idx_sum[7:0]});
                        end
                        3'h3: s_d.bus = rd(s_q.eff_addr);
                        3'h4: begin
                           s_d.operand = data_in;
                           s_d.bus = wr(s_q.eff_addr, data_in);
                        end
                        3'h5: s_d.bus = wr(s_q.eff_addr, mod_val);
                        default: s_d.bus = rd(s_q.cmd.pc + seq_pkg::PC_OFS_3);
                     endcase
                  end
                  default: s_d.bus = rd(s_q.bus.addr);
               endcase
            end
            // Latch the modified result flags at the end of the modified write
            if (is_rmw(s_q.cmd.mode) && (s_q.t == last_t(s_q.cmd.mode))) begin
               s_d.flags.carry    = mod_carry;
               s_d.flags.zero     = mod_zero;
               s_d.flags.negative = mod_neg;
            end
            // Sequence ends: next opcode fetch is on the bus, fixed length
            if (s_q.t == last_t(s_q.cmd.mode)) begin
               s_d.phase   = seq_pkg::PH_IDLE;
               s_d.busy    = 1'b0;
               s_d.done    = 1'b1;
               s_d.next_pc = s_d.bus.addr;
               s_d.t       = 3'h0;
            end
         end
         default: begin
            s_d.phase = seq_pkg::PH_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Mode tables
   // ----------------------------------------------------------------
   function automatic logic [2:0] last_t(input seq_pkg::mode_e m);
      unique case (m)
         seq_pkg::M_ST_ABS_IDX: return seq_pkg::LAST_ST_ABS_IDX;
         seq_pkg::M_ST_ZP_IDX:  return seq_pkg::LAST_ST_ZP_IDX;
         seq_pkg::M_ST_IND_Y:   return seq_pkg::LAST_ST_IND_Y;
         seq_pkg::M_ST_IND_X:   return seq_pkg::LAST_ST_IND_X;
         seq_pkg::M_RMW_ZP:     return seq_pkg::LAST_RMW_ZP;
         seq_pkg::M_RMW_ABS:    return seq_pkg::LAST_RMW_ABS;
         seq_pkg::M_RMW_ZP_X:   return seq_pkg::LAST_RMW_ZP_X;
         default:               return seq_pkg::LAST_RMW_ABS_X;
      endcase
   endfunction

   function automatic logic is_rmw(input seq_pkg::mode_e m);
      return (m == seq_pkg::M_RMW_ZP) || (m == seq_pkg::M_RMW_ABS) ||
             (m == seq_pkg::M_RMW_ZP_X) || (m == seq_pkg::M_RMW_ABS_X);
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q        <= '0;
         s_q.bus.rw <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus     = s_q.bus;
   assign flags   = s_q.flags;
   assign next_pc = s_q.next_pc;
   assign busy    = s_q.busy;
   assign done    = s_q.done;

endmodule

//--- verilog/seq_pkg.sv
// Shared types and constants of the store / read-modify-write bus sequencer.
// Assumes a single clock and a memory that answers reads in the same cycle.
package seq_pkg;

   // ----------------------------------------------------------------
   // Widths and fixed values
   // ----------------------------------------------------------------
   localparam int          ADDR_W    = 16;
   localparam int          DATA_W    = 8;
   localparam logic [7:0]  ZERO_PAGE = 8'h00;
   localparam logic [7:0]  BYTE_STEP = 8'h01;
   localparam logic [15:0] PC_OFS_1  = 16'h0001;
   localparam logic [15:0] PC_OFS_2  = 16'h0002;
   localparam logic [15:0] PC_OFS_3  = 16'h0003;

   // ----------------------------------------------------------------
   // Index of the last cycle of each sequence (cycles minus one)
   // ----------------------------------------------------------------
   localparam logic [2:0] LAST_ST_ABS_IDX  = 3'h4;
   localparam logic [2:0] LAST_ST_ZP_IDX   = 3'h3;
   localparam logic [2:0] LAST_ST_IND_Y    = 3'h5;
   localparam logic [2:0] LAST_ST_IND_X    = 3'h5;
   localparam logic [2:0] LAST_RMW_ZP      = 3'h4;
   localparam logic [2:0] LAST_RMW_ABS     = 3'h5;
   localparam logic [2:0] LAST_RMW_ZP_X    = 3'h5;
   localparam logic [2:0] LAST_RMW_ABS_X   = 3'h6;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      M_ST_ABS_IDX,
      M_ST_ZP_IDX,
      M_ST_IND_Y,
      M_ST_IND_X,
      M_RMW_ZP,
      M_RMW_ABS,
      M_RMW_ZP_X,
      M_RMW_ABS_X
   } mode_e;

   typedef enum logic [2:0] {
      OP_SHL,
      OP_SHR,
      OP_ROTL,
      OP_ROTR,
      OP_INC,
      OP_DEC
   } rmw_op_e;

   typedef enum logic {
      PH_IDLE,
      PH_RUN
   } phase_e;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      mode_e       mode;
      rmw_op_e     op;
      logic        use_y;
      logic [15:0] pc;
      logic [7:0]  x;
      logic [7:0]  y;
      logic [7:0]  store_val;
      logic        carry_in;
   } cmd_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  dout;
      logic        oe;
      logic        rw;
   } bus_s;

   typedef struct packed {
      logic carry;
      logic zero;
      logic negative;
   } flags_s;

   typedef struct packed {
      phase_e      phase;
      cmd_s        cmd;
      logic [7:0]  idx;
      logic [2:0]  t;
      logic [7:0]  ptr;
      logic [7:0]  base_addr_low;
      logic [7:0]  base_addr_high;
      logic [15:0] eff_addr;
      logic [7:0]  operand;
      bus_s        bus;
      flags_s      flags;
      logic [15:0] next_pc;
      logic        busy;
      logic        done;
   } seq_s;

endpackage

//--- verilog/rmw_alu.sv
// Modify stage of read-modify-write: shifts, rotates, increment, decrement.
// Purely combinational; the sequencer registers what it needs.
`timescale 1ns/1ps

module rmw_alu #(
   parameter int WIDTH = 8
) (
   input  wire seq_pkg::rmw_op_e op,
   input  wire logic [WIDTH-1:0] operand,
   input  wire logic             carry_in,
   output logic      [WIDTH-1:0] result,
   output logic                  carry_out,
   output logic                  zero,
   output logic                  negative
);

   // ----------------------------------------------------------------
   // Operation
   // ----------------------------------------------------------------
   always_comb begin
      result    = operand;
      carry_out = carry_in;
      unique case (op)
         seq_pkg::OP_SHL: begin
            result    = {operand[WIDTH-2:0], 1'b0};
            carry_out = operand[WIDTH-1];
         end
         seq_pkg::OP_SHR: begin
            result    = {1'b0, operand[WIDTH-1:1]};
            carry_out = operand[0];
         end
         seq_pkg::OP_ROTL: begin
            result    = {operand[WIDTH-2:0], carry_in};
            carry_out = operand[WIDTH-1];
         end
         seq_pkg::OP_ROTR: begin
            result    = {carry_in, operand[WIDTH-1:1]};
            carry_out = operand[0];
         end
         seq_pkg::OP_INC: begin
            result = operand + {{(WIDTH-1){1'b0}}, 1'b1};
         end
         seq_pkg::OP_DEC: begin
            result = operand - {{(WIDTH-1){1'b0}}, 1'b1};
         end
         default: begin
            result = operand;
         end
      endcase
      zero     = (result == '0);
      negative = result[WIDTH-1];
   end

endmodule

//--- sim/seq_properties.sv
// Port checker of the store / read-modify-write bus sequencer.
// Assumes one clock and a synchronous active-high reset; bound at the foot.
`timescale 1ns/1ps

module seq_properties #(
   parameter int DATA_W = seq_pkg::DATA_W
) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              start,
   input wire seq_pkg::cmd_s     cmd,
   input wire logic [DATA_W-1:0] data_in,
   input wire seq_pkg::bus_s     bus,
   input wire seq_pkg::flags_s   flags,
   input wire logic [15:0]       next_pc,
   input wire logic              busy,
   input wire logic              done
);
   // Per mode: cycle count, three-byte mode, store mode
   localparam logic [31:0] N_TAB   = 32'h7665_6645;
   localparam logic [7:0]  ABS_TAB = 8'ha1;
   localparam logic [7:0]  ST_TAB  = 8'h0f;
   logic [3:0]  cnt;
   logic [2:0]  wcnt;
   logic [15:0] pc_l;
   logic [7:0]  sv_l;
   logic [2:0]  mode_l;

   always_ff @(posedge clk) begin
      cnt <= (busy && !reset) ? cnt + 4'h1 : 4'h0;
      wcnt <= (busy && !reset) ? wcnt + {2'h0, !bus.rw} : 3'h0;
      if (start && !busy && !reset) begin
         pc_l <= cmd.pc;
         sv_l <= cmd.store_val;
         mode_l <= cmd.mode;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence orig_wb;
      bus.addr == $past(bus.addr) && bus.dout == $past(data_in);
   endsequence
   sequence mod_wb;
      !bus.rw && $stable(bus.addr) ##1 done;
   endsequence

   chk_oe_rw: assert property (bus.oe == !bus.rw)
      else $error("oe does not mirror rw");
   chk_start_fetch: assert property (
      start && !busy |=> busy && bus.rw && bus.addr == $past(cmd.pc))
      else $error("no opcode fetch after start");
   chk_cycle_count: assert property (
      done |-> cnt == N_TAB[{mode_l, 2'b00} +: 4])
      else $error("sequence length wrong");
   chk_next_fetch: assert property (
      done |-> bus.rw && next_pc == bus.addr
         && bus.addr == pc_l + (ABS_TAB[mode_l] ? 16'h0003 : 16'h0002))
      else $error("next opcode address wrong");
   chk_write_count: assert property (
      done |-> wcnt == (ST_TAB[mode_l] ? 3'h1 : 3'h2))
      else $error("write cycle count wrong");
   chk_store_write: assert property (
      !bus.rw && ST_TAB[mode_l] |-> bus.dout == sv_l && $past(bus.rw) ##1 done)
      else $error("store write wrong");
   chk_rmw_wb: assert property (
      $fell(bus.rw) && !ST_TAB[mode_l] |-> orig_wb ##1 mod_wb)
      else $error("write back wrong");
   chk_busy_end: assert property ($fell(busy) |-> done)
      else $error("busy ended without next fetch");
   chk_flags_time: assert property ($changed(flags) |-> done)
      else $error("flags changed outside done");
endmodule

bind store_rmw_bus_sequencer seq_properties #(.DATA_W(DATA_W)) chk_i (
   .clk(clk), .reset(reset), .start(start), .cmd(cmd), .data_in(data_in),
   .bus(bus), .flags(flags), .next_pc(next_pc), .busy(busy), .done(done));

//--- sim/bus_memory.sv
// Memory partner of the sequencer: combinational read, clocked write.
// Assumes the bus struct of seq_pkg; the bench may preload cells.
`timescale 1ns/1ps

module bus_memory (
   input  wire logic          clk,
   input  wire seq_pkg::bus_s bus,
   output logic [7:0]         data_in
);
   logic [7:0] cells [65536];

   // Reads have no side effect; write cycles return the inverted bus
   assign data_in = bus.rw ? cells[bus.addr] : ~bus.dout;
   always @(posedge clk) begin
      if (bus.oe && !bus.rw) begin
         cells[bus.addr] <= bus.dout;
      end
   end
endmodule

//--- sim/store_rmw_bus_sequencer_test.sv
// Self-checking bench of the store / read-modify-write bus sequencer.
// Assumes bus_memory as partner and seq_properties bound to dut.
`timescale 1ns/1ps

module store_rmw_bus_sequencer_test;
   logic          clk;
   logic          reset;
   logic          start;
   seq_pkg::cmd_s cmd;
   logic [7:0]    data_in;
   seq_pkg::bus_s bus;
   seq_pkg::flags_s flags;
   logic [15:0]   next_pc;
   logic          busy;
   logic          done;
   int            n_fail;
   int            n_tests;
   int            n_seen;
   logic [15:0]   ta [10];
   logic          tr [10];

   store_rmw_bus_sequencer dut (
      .clk(clk), .reset(reset), .start(start), .cmd(cmd), .data_in(data_in),
      .bus(bus), .flags(flags), .next_pc(next_pc), .busy(busy), .done(done));
   bus_memory mem (.clk(clk), .bus(bus), .data_in(data_in));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic conclude;
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
      end
   endtask

   function automatic seq_pkg::cmd_s mk(input logic [2:0] m, input logic [15:0] pc,
                                        input logic [7:0] x, y, v, input logic [2:0] op);
      return '{mode: seq_pkg::mode_e'(m), op: seq_pkg::rmw_op_e'(op), use_y: 1'b0,
               pc: pc, x: x, y: y, store_val: v, carry_in: 1'b1};
   endfunction

   // Start one sequence and trace address and rw up to the next fetch
   task automatic run(input seq_pkg::cmd_s c, input bit keep);
      int i;
      cmd = c;
      start = 1'b1;
      for (i = 0; i < 10; i++) begin
         @(negedge clk);
         if (done === 1'b1)
            break;
         ta[i] = bus.addr;
         tr[i] = bus.rw;
      end
      n_seen = i;
      if (i == 10) begin
         n_fail++;
         $display("MISMATCH t=%0t no next fetch", $time);
         conclude();
      end
      if (!keep) begin
         start = 1'b0;
         @(negedge clk);
      end
   endtask

   task automatic walk(input logic [15:0] ea [$], input logic [9:0] wm);
      chk(16'(n_seen), 16'(ea.size()));
      foreach (ea[i]) begin
         chk(ta[i], ea[i]);
         chk({15'h0000, tr[i]}, {15'h0000, !wm[i]});
      end
   endtask

   task automatic fin(input logic [15:0] nx, input logic [15:0] wa, input logic [7:0] wv);
      chk(bus.addr, nx);
      chk(next_pc, nx);
      chk({8'h00, mem.cells[wa]}, {8'h00, wv});
   endtask

   task automatic t_st_abs;
      seq_pkg::cmd_s c;
      mem.cells[16'h1001] = 8'hf0;
      mem.cells[16'h1002] = 8'h12;
      mem.cells[16'h1004] = 8'h10;
      mem.cells[16'h1005] = 8'h20;
      run(mk(3'h0, 16'h1000, 8'h20, 8'h00, 8'h5a, 3'h0), 1'b1);
      walk('{16'h1000, 16'h1001, 16'h1002, 16'h1310, 16'h1310}, 10'h010);
      fin(16'h1003, 16'h1310, 8'h5a);
      c = mk(3'h0, 16'h1003, 8'h00, 8'h01, 8'h6b, 3'h0);
      c.use_y = 1'b1;
      run(c, 1'b0);
      walk('{16'h1003, 16'h1004, 16'h1005, 16'h2011, 16'h2011}, 10'h010);
      fin(16'h1006, 16'h2011, 8'h6b);
      $display("st_abs end");
   endtask

   task automatic t_st_zp;
      mem.cells[16'h2001] = 8'hfe;
      run(mk(3'h1, 16'h2000, 8'h05, 8'h00, 8'h3c, 3'h0), 1'b0);
      walk('{16'h2000, 16'h2001, 16'h00fe, 16'h0003}, 10'h008);
      fin(16'h2002, 16'h0003, 8'h3c);
      $display("st_zp end");
   endtask

   task automatic t_st_ind_y;
      mem.cells[16'h3001] = 8'h40;
      mem.cells[16'h0040] = 8'hc0;
      mem.cells[16'h0041] = 8'h22;
      run(mk(3'h2, 16'h3000, 8'h00, 8'h50, 8'ha5, 3'h0), 1'b0);
      walk('{16'h3000, 16'h3001, 16'h0040, 16'h0041, 16'h2210, 16'h2310}, 10'h020);
      fin(16'h3002, 16'h2310, 8'ha5);
      $display("st_ind_y end");
   endtask

   task automatic t_st_ind_x;
      mem.cells[16'h4001] = 8'h80;
      mem.cells[16'h0084] = 8'h34;
      mem.cells[16'h0085] = 8'h56;
      run(mk(3'h3, 16'h4000, 8'h04, 8'h00, 8'h77, 3'h0), 1'b0);
      walk('{16'h4000, 16'h4001, 16'h0080, 16'h0084, 16'h0085, 16'h5634}, 10'h020);
      fin(16'h4002, 16'h5634, 8'h77);
      $display("st_ind_x end");
   endtask

   task automatic t_rmw_zp;
      logic [7:0] res [6];
      logic [2:0] fx [6];
      res = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'h82, 8'h80};
      fx = '{3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
      mem.cells[16'h5001] = 8'h10;
      for (int k = 0; k < 6; k++) begin
         mem.cells[16'h0010] = 8'h81;
         run(mk(3'h4, 16'h5000, 8'h00, 8'h00, 8'h00, 3'(k)), 1'b0);
         walk('{16'h5000, 16'h5001, 16'h0010, 16'h0010, 16'h0010}, 10'h018);
         fin(16'h5002, 16'h0010, res[k]);
         chk({13'h0000, flags}, {13'h0000, fx[k]});
      end
      $display("rmw_zp end");
   endtask

   task automatic t_rmw_abs;
      mem.cells[16'h6001] = 8'h34;
      mem.cells[16'h6002] = 8'h12;
      mem.cells[16'h1234] = 8'h7f;
      run(mk(3'h5, 16'h6000, 8'h00, 8'h00, 8'h00, 3'h4), 1'b0);
      walk('{16'h6000, 16'h6001, 16'h6002, 16'h1234, 16'h1234, 16'h1234}, 10'h030);
      fin(16'h6003, 16'h1234, 8'h80);
      $display("rmw_abs end");
   endtask

   task automatic t_rmw_zp_x;
      mem.cells[16'h7001] = 8'hf0;
      mem.cells[16'h0010] = 8'h01;
      run(mk(3'h6, 16'h7000, 8'h20, 8'h00, 8'h00, 3'h5), 1'b0);
      walk('{16'h7000, 16'h7001, 16'h00f0, 16'h0010, 16'h0010, 16'h0010}, 10'h030);
      fin(16'h7002, 16'h0010, 8'h00);
      $display("rmw_zp_x end");
   endtask

   task automatic t_rmw_abs_x;
      mem.cells[16'h8001] = 8'hf0;
      mem.cells[16'h8002] = 8'h12;
      mem.cells[16'h1310] = 8'h40;
      run(mk(3'h7, 16'h8000, 8'h20, 8'h00, 8'h00, 3'h0), 1'b0);
      walk('{16'h8000, 16'h8001, 16'h8002, 16'h1310, 16'h1310, 16'h1310, 16'h1310},
           10'h060);
      fin(16'h8003, 16'h1310, 8'h80);
      $display("rmw_abs_x end");
   endtask

   initial begin
      n_fail = 0;
      n_tests = 0;
      reset = 1'b1;
      start = 1'b0;
      cmd = '0;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      t_st_abs();
      t_st_zp();
      t_st_ind_y();
      t_st_ind_x();
      t_rmw_zp();
      t_rmw_abs();
      t_rmw_zp_x();
      t_rmw_abs_x();
      conclude();
   end
endmodule
